// ---- imu_offset_gain_compensation.sv ----
// Offset, gain and gyro self-test logic of a six-axis inertial sensor.
// Assumes synchronous sample inputs and an AXI4-Lite master on the bus side.
// What this block does
// - At self-test end set done flag and report ok or error status.
// - Self-test passes only when x, y and z ok flags are all one.
// - Gyro startup is gyro enable rising without fast power-up, or vice versa.
// - Drive test on self-test and startup; failure sets fatal within 320 ms.
// - Offset computed on raw samples and applied before the optional gyro gain.
// - Offset sum that overflows clamps to most negative or positive value.
// - Accel offsets load from stored copies at reset, host may overwrite.
// - First sample after any host offset write is marked invalid.
// - Accel offset is 8-bit two's complement, range independent.
// - Accel offset applied only while its enable bit is set.
// - Gyro offset is 10-bit two's complement, used only when enabled.
// - Gyro offsets load from stored images at reset, host may overwrite.
// - Automatic gyro offset tracking only when all five conditions hold.
// - Gain ratio is 11-bit unsigned 1.10, spanning 0.75 to 1.25.
// - Device clears update enable when the gain update is finished.
// - Gain correction at its range limit is flagged in gain status.
`default_nettype none
module imu_offset_gain_compensation
  import imu_cal_pkg::*;
#(
  parameter int unsigned DRIVE_CYCLES  = 32'(DRIVE_TEST_CYC),
  parameter int unsigned ACC_OFF_SHIFT = 0,
  parameter int unsigned GYR_OFF_SHIFT = 0
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire axis_s       acc_in,
  input  wire axis_s       gyr_in,
  input  wire logic        in_valid,
  input  wire logic        drive_ok,
  input  wire logic [2:0]  sense_ok,
  input  wire logic        ois_acc_en,
  input  wire logic        ois_gyr_en,
  input  wire logic        ioc_valid,
  input  wire logic [29:0] ioc_offset,
  input  wire logic [23:0] nvm_acc_off,
  input  wire logic [29:0] nvm_gyr_off,
  input  wire logic [3:0]  nvm_cfg,
  output var  axis_s       acc_out,
  output var  axis_s       gyr_out,
  output var  logic        out_valid,
  output var  logic        out_invalid,
  output var  logic        fatal_err,
  output var  logic        tracking_active
);
  if (DRIVE_CYCLES < 2 || ACC_OFF_SHIFT > 8 || GYR_OFF_SHIFT > 6) begin : g_chk
    $error("imu_offset_gain_compensation: unsupported parameter value");
  end
  // ----------------------------------------------------------------------
  // Helper functions and state
  // ----------------------------------------------------------------------
  // Saturating add of sample and offset
  function automatic logic signed [15:0] add_sat(input logic signed [15:0] s,
                                                 input logic signed [15:0] o);
    logic signed [16:0] t;
    t = 17'(s) + 17'(o);
    return (t > 17'sd32767) ? 16'sh7FFF : (t < -17'sd32768) ? 16'sh8000 : t[15:0];
  endfunction
  // Scale by 1.10 ratio with saturation
  function automatic logic signed [15:0] gain_sat(input logic signed [15:0] s,
                                                  input logic [10:0] g);
    logic signed [27:0] p;
    logic signed [17:0] q;
    p = 28'(s) * 28'($signed({1'b0, g}));
    q = p[27:10];
    return (q > 18'sd32767) ? 16'sh7FFF : (q < -18'sd32768) ? 16'sh8000 : q[15:0];
  endfunction
  function automatic logic [10:0] clamp_gain(input logic [10:0] g);
    return (g > GAIN_MAX) ? GAIN_MAX : (g < GAIN_MIN) ? GAIN_MIN : g;
  endfunction
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb, pwr, pwr_prev, cfg;
  logic [23:0]       acc_off;
  logic [29:0]       gyr_off;
  logic [2:0][10:0]  gain_req, gain_new, gain_act;
  logic              upd_en, gain_limit, boot_load, selftest, st_done, inv_pend, v1, inv1;
  st_e               state;
  logic [31:0]       cnt;
  logic [2:0]        axis_ok;
  logic [1:0]        trig_status;
  axis_s             acc_s1, gyr_s1;
  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire do_write  = !awready && !wready && !bvalid;
  wire ar_take   = arvalid && arready;
  wire wr_cmd    = do_write && aw_addr == A_CMD && w_strb[0];
  wire wr_pwr    = do_write && aw_addr == A_PWR;
  wire wr_acc    = do_write && aw_addr == A_ACC_OFF;
  wire wr_gyr    = do_write && aw_addr == A_GYR_OFF;
  wire wr_cfg    = do_write && aw_addr == A_CFG;
  wire wr_gxy    = do_write && aw_addr == A_GAIN_XY;
  wire wr_gz     = do_write && aw_addr == A_GAIN_Z;
  wire wr_hit    = aw_addr <= A_STATUS && aw_addr[1:0] == 2'b00;
  wire rd_hit    = araddr <= A_STATUS && araddr[1:0] == 2'b00;
  wire cmd_trig  = wr_cmd && w_data[7:0] == CMD_GTRIG;
  wire cmd_gain  = wr_cmd && w_data[7:0] == CMD_UGAIN;
  wire cmd_srst  = wr_cmd && w_data[7:0] == CMD_SOFTRST;
  wire [31:0] st_word = {21'h0, tracking_active, 1'b0, gain_limit, fatal_err,
                         trig_status, st_done && &axis_ok, axis_ok, st_done};
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wr_acc_v = ({8'h0, acc_off} & ~wmask) | (w_data & wmask);
  wire [31:0] wr_gyr_v = ({2'h0, gyr_off} & ~wmask) | (w_data & wmask);
  wire [31:0] wr_gxy_v = ({5'h0, gain_req[1], 5'h0, gain_req[0]} & ~wmask) | (w_data & wmask);
  wire [31:0] wr_gz_v  = ({15'h0, upd_en, 5'h0, gain_req[2]} & ~wmask) | (w_data & wmask);
  logic [31:0] rd_mux;
  always_comb begin
    case (araddr)
      A_PWR:     rd_mux = {28'h0, pwr};
      A_ACC_OFF: rd_mux = {8'h0, acc_off};
      A_GYR_OFF: rd_mux = {2'h0, gyr_off};
      A_CFG:     rd_mux = {28'h0, cfg};
      A_GAIN_XY: rd_mux = {5'h0, gain_req[1], 5'h0, gain_req[0]};
      A_GAIN_Z:  rd_mux = {15'h0, upd_en, 5'h0, gain_req[2]};
      A_STATUS:  rd_mux = st_word;
      default:   rd_mux = 32'h0;
    endcase
  end
  // ----------------------------------------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? RESP_OK : RESP_SLV;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OK;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= rd_hit ? RESP_OK : RESP_SLV;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // Power, configuration, offset and gain registers
  // ----------------------------------------------------------------------
  wire tracking = cfg[CFG_SELF] && cfg[CFG_GOFF] && (pwr[PWR_ACC] || ois_acc_en)
                  && pwr[PWR_GYR] && !ois_gyr_en;
  wire gyr_start = (pwr[PWR_GYR] && !pwr_prev[PWR_GYR] && !pwr[PWR_FUP])
                || (pwr[PWR_FUP] && !pwr_prev[PWR_FUP] && !pwr[PWR_GYR]);
  // load stored images after reset or soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_load <= 1'b1;
      pwr       <= PWR_RST;
      pwr_prev  <= PWR_RST;
      acc_off   <= 24'h0;
      gyr_off   <= 30'h0;
      cfg       <= 4'h0;
      tracking_active <= 1'b0;
    end else begin
      pwr_prev        <= pwr;
      tracking_active <= tracking;
      boot_load       <= cmd_srst;
      if (boot_load) begin
        pwr     <= PWR_RST;
        acc_off <= nvm_acc_off;
        gyr_off <= nvm_gyr_off;
        cfg     <= nvm_cfg;
      end else begin
        if (wr_pwr && w_strb[0]) pwr <= w_data[3:0];
        if (wr_cfg && w_strb[0]) cfg <= w_data[3:0];
        if (wr_acc) acc_off <= wr_acc_v[23:0];
        // autonomous tracking wins over a host write
        if (tracking && ioc_valid) gyr_off <= ioc_offset;
        else if (wr_gyr) gyr_off <= wr_gyr_v[29:0];
      end
    end
  end
  // Gain ratios and user gain update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_req   <= {3{GAIN_ONE}};
      gain_new   <= {3{GAIN_ONE}};
      gain_act   <= {3{GAIN_ONE}};
      upd_en     <= 1'b0;
      gain_limit <= 1'b0;
    end else begin
      if (wr_gxy) begin
        gain_req[0] <= wr_gxy_v[10:0];
        gain_req[1] <= wr_gxy_v[26:16];
      end
      if (wr_gz) begin
        gain_req[2] <= wr_gz_v[10:0];
        upd_en      <= wr_gz_v[GAIN_UPD_EN];
      end
      // clamp to range, flag limit, clear enable
      if (cmd_gain && upd_en && !pwr[PWR_GYR]) begin
        for (int i = 0; i < 3; i++) gain_new[i] <= clamp_gain(gain_req[i]);
        gain_limit <= (gain_req[0] >= GAIN_MAX) || (gain_req[0] <= GAIN_MIN)
                   || (gain_req[1] >= GAIN_MAX) || (gain_req[1] <= GAIN_MIN)
                   || (gain_req[2] >= GAIN_MAX) || (gain_req[2] <= GAIN_MIN);
        upd_en <= 1'b0;
      end
      // new ratios take effect at the next gyro start
      if (gyr_start) gain_act <= gain_new;
    end
  end
  // ----------------------------------------------------------------------
  // Self-test and drive test sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= ST_IDLE;
      cnt         <= 32'h0;
      selftest    <= 1'b0;
      st_done     <= 1'b0;
      axis_ok     <= 3'h0;
      trig_status <= TRIG_OK;
      fatal_err   <= 1'b0;
    end else begin
      // Fatal flag clears on status read; a new failure wins
      if (ar_take && araddr == A_STATUS) fatal_err <= 1'b0;
      case (state)
        ST_IDLE: begin
          cnt <= 32'h0;
          if (cmd_trig) begin
            state    <= ST_DRIVE;
            selftest <= 1'b1;
            st_done  <= 1'b0;
            axis_ok  <= 3'h0;
          end else if (gyr_start) begin
            state    <= ST_DRIVE;
            selftest <= 1'b0;
          end
        end
        // drive test runs its full length, then reports
        ST_DRIVE: begin
          cnt <= cnt + 32'h1;
          if (cnt == DRIVE_CYCLES - 1) begin
            if (!drive_ok) fatal_err <= 1'b1;
            trig_status <= drive_ok ? TRIG_OK : TRIG_ERR;
            state <= selftest ? ST_SENSE : ST_IDLE;
          end
        end
        ST_SENSE: begin
          axis_ok <= sense_ok;
          st_done <= 1'b1;
          state   <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // Sample datapath: offset then gain
  // ----------------------------------------------------------------------
  // accel offset sign-extended and scaled, gated by enable
  wire signed [15:0] ao_x = cfg[CFG_AOFF] ? 16'($signed(acc_off[7:0]))   <<< ACC_OFF_SHIFT : '0;
  wire signed [15:0] ao_y = cfg[CFG_AOFF] ? 16'($signed(acc_off[15:8]))  <<< ACC_OFF_SHIFT : '0;
  wire signed [15:0] ao_z = cfg[CFG_AOFF] ? 16'($signed(acc_off[23:16])) <<< ACC_OFF_SHIFT : '0;
  // gyro offset 10-bit fields, gated by enable
  wire signed [15:0] go_x = cfg[CFG_GOFF] ? 16'($signed(gyr_off[9:0]))   <<< GYR_OFF_SHIFT : '0;
  wire signed [15:0] go_y = cfg[CFG_GOFF] ? 16'($signed(gyr_off[19:10])) <<< GYR_OFF_SHIFT : '0;
  wire signed [15:0] go_z = cfg[CFG_GOFF] ? 16'($signed(gyr_off[29:20])) <<< GYR_OFF_SHIFT : '0;
  wire off_write = wr_acc || wr_gyr;
  wire axis_s gyr_g = '{gain_sat(gyr_s1.x, gain_act[0]), gain_sat(gyr_s1.y, gain_act[1]),
                        gain_sat(gyr_s1.z, gain_act[2])};
  // saturated offset on raw samples, one result for all paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_s1   <= '0;
      gyr_s1   <= '0;
      v1       <= 1'b0;
      inv1     <= 1'b0;
      inv_pend <= 1'b0;
    end else begin
      v1 <= in_valid;
      // pending mark survives a write that meets a sample
      inv1     <= in_valid && inv_pend;
      inv_pend <= off_write || (inv_pend && !in_valid);
      if (in_valid) begin
        acc_s1 <= '{add_sat(acc_in.x, ao_x), add_sat(acc_in.y, ao_y),
                    add_sat(acc_in.z, ao_z)};
        gyr_s1 <= '{add_sat(gyr_in.x, go_x), add_sat(gyr_in.y, go_y),
                    add_sat(gyr_in.z, go_z)};
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_out     <= '0;
      gyr_out     <= '0;
      out_valid   <= 1'b0;
      out_invalid <= 1'b0;
    end else begin
      out_valid   <= v1;
      out_invalid <= inv1;
      if (v1) begin
        acc_out <= acc_s1;
        gyr_out <= cfg[CFG_GAIN] ? gyr_g : gyr_s1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- imu_cal_pkg.sv ----
// Constants and types shared by the IMU offset and gain calibration block.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none

package imu_cal_pkg;

  // ----------------------------------------------------------------------
  // Timing, addresses, commands, fields
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ          = 100_000_000;
  localparam longint DRIVE_TEST_MS   = 320;
  // Longest time, so rounded down
  localparam longint DRIVE_TEST_CYC  = (DRIVE_TEST_MS * CLK_HZ) / 1000;
  // Register byte addresses
  localparam logic [7:0] A_CMD      = 8'h00;
  localparam logic [7:0] A_PWR      = 8'h04;
  localparam logic [7:0] A_ACC_OFF  = 8'h08;
  localparam logic [7:0] A_GYR_OFF  = 8'h0C;
  localparam logic [7:0] A_CFG      = 8'h10;
  localparam logic [7:0] A_GAIN_XY  = 8'h14;
  localparam logic [7:0] A_GAIN_Z   = 8'h18;
  localparam logic [7:0] A_STATUS   = 8'h1C;
  // Commands, bit positions, reset values
  localparam logic [7:0] CMD_GTRIG  = 8'h02;
  localparam logic [7:0] CMD_UGAIN  = 8'h03;
  localparam logic [7:0] CMD_SOFTRST = 8'hB6;
  localparam int PWR_ACC  = 0;
  localparam int PWR_GYR  = 1;
  localparam int PWR_FUP  = 2;
  localparam int PWR_APS  = 3;
  localparam int CFG_AOFF = 0;
  localparam int CFG_GOFF = 1;
  localparam int CFG_GAIN = 2;
  localparam int CFG_SELF = 3;
  localparam int GAIN_UPD_EN = 16;
  localparam logic [3:0]  PWR_RST   = 4'h8;
  localparam logic [10:0] GAIN_ONE  = 11'h400;
  localparam logic [10:0] GAIN_MIN  = 11'h300;
  localparam logic [10:0] GAIN_MAX  = 11'h500;
  localparam logic [1:0]  TRIG_OK   = 2'h0;
  localparam logic [1:0]  TRIG_ERR  = 2'h1;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } axis_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRIVE = 2'b01,
    ST_SENSE = 2'b10
  } st_e;

endpackage

`default_nettype wire

// ---- imu_cal_checker.sv ----
// Checker: bus and datapath timing of the calibration block.
// Assumes it is bound to the ports of the top module.
`default_nettype none
module imu_cal_checker
  import imu_cal_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        in_valid,
  input wire logic        out_valid,
  input wire logic        out_invalid,
  input wire logic        fatal_err,
  input wire logic        ois_gyr_en,
  input wire logic        tracking_active
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rd_lat; arvalid && arready |=> rvalid; endproperty
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_aw_block; bvalid |-> !awready; endproperty
  property p_unmapped;
    arvalid && arready && (araddr > A_STATUS || araddr[1:0] != 2'h0)
      |=> rresp == RESP_SLV && rdata == 32'h0;
  endproperty
  property p_out_lat; in_valid |-> ##2 out_valid; endproperty
  property p_inv_pair; out_invalid |-> out_valid; endproperty
  property p_fatal_keep;
    fatal_err && !(arvalid && arready && araddr == A_STATUS) |=> fatal_err;
  endproperty
  property p_track_off; ois_gyr_en |=> !tracking_active; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_aw_block: assert property (p_aw_block) else $error("address taken during response");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_out_lat: assert property (p_out_lat) else $error("sample latency wrong");
  a_inv_pair: assert property (p_inv_pair) else $error("invalid mark alone");
  a_fatal_keep: assert property (p_fatal_keep) else $error("fatal flag lost");
  a_track_off: assert property (p_track_off) else $error("tracking with side port");
  c_fatal: cover property ($rose(fatal_err));
  c_invalid: cover property (out_invalid);
  c_slverr: cover property (rvalid && rresp == RESP_SLV);
endmodule
bind imu_offset_gain_compensation imu_cal_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .awready(awready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .in_valid(in_valid), .out_valid(out_valid), .out_invalid(out_invalid),
  .fatal_err(fatal_err), .ois_gyr_en(ois_gyr_en), .tracking_active(tracking_active));
`default_nettype wire

// ---- imu_host_model.sv ----
// Host model: AXI4-Lite master that reaches the calibration registers.
// Assumes its tasks are called by the bench, one transfer at a time.
`default_nettype none
module imu_host_model (
  input  wire logic        aclk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Write one word, hold each channel until taken
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r, output logic h);
    h = 1'b1;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 50 && h; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        h = 1'b0;
        bready <= 1'b0;
      end
    end
  endtask
  // Read one word
  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r, output logic h);
    h = 1'b1;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 50 && h; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        h = 1'b0;
        rready <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- imu_offset_gain_compensation_tb.sv ----
// Testbench: self-checking run of the calibration block.
// Assumes the host model and checker are compiled before it.
`default_nettype none
module imu_offset_gain_compensation_tb import imu_cal_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, out_valid, out_invalid;
  logic        fatal_err, tracking_active;
  axis_s       acc_in = '0, gyr_in = '0, acc_out, gyr_out;
  logic        in_valid = 1'b0, drive_ok = 1'b1, ois_acc_en = 1'b0, ois_gyr_en = 1'b0;
  logic        ioc_valid = 1'b0;
  logic [2:0]  sense_ok = 3'h7;
  logic [29:0] ioc_offset = 30'h0, nvm_gyr_off = 30'h0050_0C03;
  logic [23:0] nvm_acc_off = 24'h12_3456;
  logic [3:0]  nvm_cfg = 4'h6;
  int          failures = 0, checked = 0;
  // ----------------------------------------------------------------------
  // Clock and instances
  // ----------------------------------------------------------------------
  always #5 aclk = ~aclk;
  imu_offset_gain_compensation #(.DRIVE_CYCLES(8)) i_imu_offset_gain_compensation (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .acc_in, .gyr_in, .in_valid, .drive_ok, .sense_ok, .ois_acc_en, .ois_gyr_en,
    .ioc_valid, .ioc_offset, .nvm_acc_off, .nvm_gyr_off, .nvm_cfg, .acc_out, .gyr_out,
    .out_valid, .out_invalid, .fatal_err, .tracking_active);
  imu_host_model i_imu_host_model (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready);
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("mismatches %0d of %0d compares", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    failures++;
    $display("BAD %0t no answer", $time);
    summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OK);
    logic [1:0] r;
    logic       h;
    i_imu_host_model.write(a, d, r, h);
    if (h) hang();
    chk(48'(r), 48'(e));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e = RESP_OK);
    logic [1:0] r;
    logic       h;
    i_imu_host_model.read(a, d, r, h);
    if (h) hang();
    chk(48'(r), 48'(e));
  endtask
  // Read until masked bits match
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                      output logic [31:0] d);
    for (int n = 0; n < 40; n++) begin
      rd(a, d);
      if ((d & m) === v) return;
    end
    hang();
  endtask
  // One sample in, wait for its corrected output
  task automatic send(input axis_s a, input axis_s g);
    @(posedge aclk);
    acc_in   <= a;
    gyr_in   <= g;
    in_valid <= 1'b1;
    @(posedge aclk);
    in_valid <= 1'b0;
    acc_in   <= ~a;
    gyr_in   <= ~g;
    for (int n = 0; n < 8; n++) begin
      @(posedge aclk);
      if (out_valid === 1'b1) return;
    end
    hang();
  endtask
  task automatic wait_fatal();
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (fatal_err === 1'b1) return;
    end
    hang();
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_boot();
    logic [31:0] d;
    rd(A_PWR, d);
    chk(48'(d), 48'(PWR_RST));
    rd(A_ACC_OFF, d);
    chk(48'(d), 48'(nvm_acc_off));
    rd(A_GYR_OFF, d);
    chk(48'(d), 48'(nvm_gyr_off));
    rd(8'h20, d, RESP_SLV);
    chk(48'(d), 48'h0);
    wr(8'h22, 32'h1, RESP_SLV);
  endtask
  task automatic t_selftest();
    logic [31:0] d;
    wr(A_PWR, 32'h0);
    repeat (45000) @(posedge aclk);
    wr(A_PWR, 32'h1);
    for (int s = 0; s < 8; s++) begin
      sense_ok <= 3'(s);
      wr(A_CMD, 32'(CMD_GTRIG));
      poll(A_STATUS, 32'h1, 32'h1, d);
      chk(48'(d[6:0]), 48'({TRIG_OK, s == 7, 3'(s), 1'b1}));
    end
  endtask
  task automatic t_drive();
    logic [31:0] d;
    drive_ok <= 1'b0;
    wr(A_CMD, 32'(CMD_GTRIG));
    wait_fatal();
    rd(A_STATUS, d);
    chk(48'(d[7]), 48'h1);
    poll(A_STATUS, 32'h1, 32'h1, d);
    chk(48'(d[6:5]), 48'(TRIG_ERR));
    wr(A_PWR, 32'h2);
    wait_fatal();
    rd(A_STATUS, d);
    chk(48'(fatal_err), 48'h0);
    wr(A_PWR, 32'h0);
    wr(A_PWR, 32'h4);
    wait_fatal();
    rd(A_STATUS, d);
    wr(A_PWR, 32'h6);
    repeat (20) @(posedge aclk);
    chk(48'(fatal_err), 48'h0);
    drive_ok <= 1'b1;
  endtask
  task automatic t_offset();
    axis_s a = '{16'sh7FF0, 16'sh8005, 16'sh0010};
    axis_s g = '{16'sh7F00, 16'sh8100, 16'sh0000};
    wr(A_CFG, 32'h1);
    wr(A_ACC_OFF, 32'h01_807F);
    send(a, '0);
    chk(48'(out_invalid), 48'h1);
    send(a, '0);
    chk(48'(out_invalid), 48'h0);
    chk(acc_out, 48'h7FFF_8000_0011);
    wr(A_CFG, 32'h0);
    send(a, '0);
    chk(acc_out, a);
    wr(A_CFG, 32'h2);
    wr(A_GYR_OFF, 32'h0008_01FF);
    send('0, g);
    send('0, g);
    chk(gyr_out, 48'h7FFF_8000_0000);
  endtask
  task automatic t_gain();
    logic [31:0] d;
    wr(A_PWR, 32'h0);
    wr(A_GAIN_XY, 32'h0200_0500);
    wr(A_GAIN_Z, 32'h0001_0400);
    wr(A_CMD, 32'(CMD_UGAIN));
    poll(A_GAIN_Z, 32'h1_0000, 32'h0, d);
    rd(A_STATUS, d);
    chk(48'(d[8]), 48'h1);
    wr(A_CFG, 32'h4);
    wr(A_PWR, 32'h2);
    send('0, '{16'sh1000, 16'sh1000, 16'sh1000});
    chk(gyr_out, 48'h1400_0C00_1000);
  endtask
  task automatic t_track();
    logic [31:0] d;
    wr(A_CFG, 32'hA);
    wr(A_PWR, 32'h3);
    repeat (3) @(posedge aclk);
    chk(48'(tracking_active), 48'h1);
    ioc_offset <= 30'h155;
    ioc_valid  <= 1'b1;
    @(posedge aclk);
    ioc_valid <= 1'b0;
    rd(A_GYR_OFF, d);
    chk(48'(d), 48'h155);
    ois_gyr_en <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(48'(tracking_active), 48'h0);
    wr(A_CMD, 32'(CMD_SOFTRST));
    repeat (2) @(posedge aclk);
    rd(A_ACC_OFF, d);
    chk(48'(d), 48'(nvm_acc_off));
    rd(A_PWR, d);
    chk(48'(d), 48'(PWR_RST));
  endtask
  // Reset, then run every scenario
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_boot();
    t_selftest();
    t_drive();
    t_offset();
    t_gain();
    t_track();
    summarize();
  end
endmodule
`default_nettype wire
